// file: hw/dfwp_fuse_word.sv
// fuse word loader and program-memory access guard of the device.
// assumes: program memory and fuse cell read asynchronously (data valid in
// the cycle of the address), reset unit gives a por flag on this clock.
//
// Operation
// - the settings live in one non-volatile word at 2007h and all enables decode from it.
// - bit 13 low turns debug mode on, high keeps it off.
// - bits 11-10 lock nothing, 000h-3FFh, 000h-7FFh or all up to FFFh from self-writes.
// - bit 8 high enables brown-out reset while running but not in sleep, low disables it.
// - bit 6 low blocks all external reads and writes of program memory.
// - a protected external read of program memory returns all zeros.
// - cpu fetches and reads ignore code protection, cpu writes obey only the lock range.
// - bit 5 high makes the pin an external reset with pull-up, low gives it its other use.
// - bit 4 low enables the power-up timer, high disables it.
// - bit 3 high turns the watchdog on, low leaves it off.
// - bits 12, 9, 7 and 2-0 have no function and read as zero.
// - cpu write permission follows the lock range, programmer write permission the code protection.
// - id words 2000h-2003h are hidden from the cpu but open to the programmer.
// - with the power-up timer on, reset after power-on is stretched.
//
// The plain strobed port was chosen for this implementation.

`timescale 1ns/1ps
`default_nettype none

module dfwp_fuse_word #(
  parameter int unsigned POWERUP_TIMER_CYCLES_P = dfwp_pkg::POWERUP_TIMER_CYCLES
) (
  // clock and reset
  input  wire logic               i_mclk,
  input  wire logic               i_rst_n,
  // reset unit and power state
  input  wire logic               i_last_reset_por,
  input  wire logic               i_sleep,
  // program/verify mode entry pin
  input  wire logic               i_prog_mode_pin,
  // external programmer port
  input  wire logic [13:0]        i_pgm_addr,
  input  wire logic [13:0]        i_pgm_wdata,
  input  wire logic               i_pgm_wr,
  input  wire logic               i_pgm_rd,
  output logic      [13:0]        o_pgm_rdata,
  output logic                    o_pgm_wr_blocked,
  // cpu port
  input  wire logic [13:0]        i_cpu_addr,
  input  wire logic [13:0]        i_cpu_wdata,
  input  wire logic               i_cpu_wr,
  input  wire logic               i_cpu_rd,
  output logic      [13:0]        o_cpu_rdata,
  output logic                    o_cpu_wr_blocked,
  // program memory array
  output logic      [13:0]        o_mem_addr,
  output logic      [13:0]        o_mem_wdata,
  output logic                    o_mem_wr,
  input  wire logic [13:0]        i_mem_rdata,
  // non-volatile fuse cell
  input  wire logic [13:0]        i_fuse_nv,
  output logic      [13:0]        o_fuse_wdata,
  output logic                    o_fuse_wr,
  // decoded settings
  output dfwp_pkg::dfwp_cfg_s     o_cfg,
  output logic                    o_debug_mode_en,
  output logic                    o_brownout_reset_en,
  output logic                    o_ext_reset_pin_en,
  output logic                    o_reset_pin_pullup_en,
  output logic                    o_powerup_timer_en,
  output logic                    o_watchdog_en,
  // start-up status
  output logic                    o_core_reset_hold,
  output logic                    o_cfg_valid,
  output logic                    o_prog_mode
);
  import dfwp_pkg::*;

  dfwp_st_s  st_r;
  dfwp_st_s  st_nxt;
  dfwp_cfg_s cfg;

  logic       pgm_in_pm;
  logic       pgm_in_id;
  logic       pgm_in_cfg;
  logic       code_locked;
  logic       cpu_in_pm;
  logic       cpu_locked;
  logic       pgm_wr_ok;
  logic       cpu_wr_ok;
  logic [13:0] lock_end;
  logic [13:0] fresh_word;

  // field split of the latched word
  always_comb begin
    cfg.debug_enable_n         = st_r.cfg_word[DEBUG_EN_N_BIT];
    cfg.self_write_lock_range  = {st_r.cfg_word[WRT_HI_BIT],
                                  st_r.cfg_word[WRT_LO_BIT]};
    cfg.brownout_reset_enable  = st_r.cfg_word[BOR_EN_BIT];
    cfg.code_protect_n         = st_r.cfg_word[CP_N_BIT];
    cfg.ext_reset_pin_select   = st_r.cfg_word[RST_PIN_SEL_BIT];
    cfg.powerup_timer_enable_n = st_r.cfg_word[POWERUP_TIMER_EN_N_BIT];
    cfg.watchdog_enable        = st_r.cfg_word[WDT_EN_BIT];
  end

  // the fresh word with dead bits forced to zero
  assign fresh_word = i_fuse_nv & CFG_IMPL_MASK;

  // address decode of both requesters
  assign pgm_in_pm  = (i_pgm_addr <= PM_LAST_ADDR);
  assign pgm_in_id  = (i_pgm_addr >= ID_FIRST_ADDR) &&
                      (i_pgm_addr <= ID_LAST_ADDR);
  assign pgm_in_cfg = (i_pgm_addr == CFG_WORD_ADDR);
  assign cpu_in_pm  = (i_cpu_addr <= PM_LAST_ADDR);

  // protection is active low in the word
  assign code_locked = ~cfg.code_protect_n;

  // end of the self-write locked region per range code
  always_comb begin
    lock_end   = PM_LAST_ADDR;
    cpu_locked = 1'b1;
    unique case (cfg.self_write_lock_range)
      WRT_OFF: begin
        lock_end   = DATA_ZERO;
        cpu_locked = 1'b0;
      end
      WRT_LOW: begin
        lock_end   = LOCK_LOW_END;
        cpu_locked = (i_cpu_addr <= lock_end);
      end
      WRT_HALF: begin
        lock_end   = LOCK_HALF_END;
        cpu_locked = (i_cpu_addr <= lock_end);
      end
      WRT_ALL: begin
        lock_end   = PM_LAST_ADDR;
        cpu_locked = 1'b1;
      end
    endcase
  end

  // programmer writes follow code protection only; ids always open
  assign pgm_wr_ok = st_r.prog_mode &&
                     ((pgm_in_pm && !code_locked) || pgm_in_id);

  // cpu writes follow the lock range only, ids never reachable
  assign cpu_wr_ok = !st_r.prog_mode && cpu_in_pm &&
                     !cpu_locked;

  // one memory port; the programmer owns it in program/verify mode
  always_comb begin
    if (st_r.prog_mode) begin
      o_mem_addr  = i_pgm_addr;
      o_mem_wdata = i_pgm_wdata;
      o_mem_wr    = i_pgm_wr && pgm_wr_ok;
    end else begin
      o_mem_addr  = i_cpu_addr;
      o_mem_wdata = i_cpu_wdata;
      o_mem_wr    = i_cpu_wr && cpu_wr_ok;
    end
  end

  // fuse cell is written only by the programmer; latches stay untouched
  assign o_fuse_wdata = i_pgm_wdata;
  assign o_fuse_wr    = i_pgm_wr && st_r.prog_mode && pgm_in_cfg;

  // next-state logic of the whole block
  always_comb begin
    st_nxt = st_r;

    // three-stage pin synchroniser, change taken when stages 2 and 3 agree
    st_nxt.pin_sync = {st_r.pin_sync[1:0], i_prog_mode_pin};
    if (st_r.pin_sync[2] == st_r.pin_sync[1]) begin
      st_nxt.prog_mode = st_r.pin_sync[2];
    end

    // start-up sequence: latch the word once, then optional stretch
    unique case (st_r.phase)
      PH_LOAD: begin
        st_nxt.cfg_word = fresh_word;
        st_nxt.powerup_timer_cnt = POWERUP_TIMER_CNT_W'(POWERUP_TIMER_CYCLES_P - 1);
        // power-up timer is active low in the word
        if (i_last_reset_por && !fresh_word[POWERUP_TIMER_EN_N_BIT]) begin
          st_nxt.phase = PH_POWERUP_TIMER;
        end else begin
          st_nxt.phase = PH_RUN;
        end
      end
      PH_POWERUP_TIMER: begin
        if (st_r.powerup_timer_cnt == '0) begin
          st_nxt.phase = PH_RUN;
        end else begin
          st_nxt.powerup_timer_cnt = st_r.powerup_timer_cnt - 1'b1;
        end
      end
      PH_RUN: begin
        st_nxt.phase = PH_RUN;  // latched word held until reset
      end
      default: begin
        st_nxt.phase = PH_LOAD;
      end
    endcase

    // programmer read data, one cycle after the strobe
    st_nxt.pgm_rdata = DATA_ZERO;
    if (i_pgm_rd && st_r.prog_mode) begin
      if (pgm_in_pm) begin
        // protected reads hide the array behind zeros
        st_nxt.pgm_rdata = code_locked ? DATA_ZERO
                                       : i_mem_rdata;
      end else if (pgm_in_id) begin
        st_nxt.pgm_rdata = i_mem_rdata;
      end else if (pgm_in_cfg) begin
        st_nxt.pgm_rdata = fresh_word;
      end
    end

    // cpu read data ignores code protection; ids and fuse stay hidden
    st_nxt.cpu_rdata = DATA_ZERO;
    if (i_cpu_rd && !st_r.prog_mode && cpu_in_pm) begin
      st_nxt.cpu_rdata = i_mem_rdata;
    end

    // refusal pulses, one cycle after the dropped write
    st_nxt.cpu_wr_blocked = i_cpu_wr && !cpu_wr_ok;
    st_nxt.pgm_wr_blocked = i_pgm_wr && !pgm_wr_ok && !pgm_in_cfg;
  end

  // single state register, synchronous reset
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_r.pin_sync       <= 3'h0;
      st_r.prog_mode      <= 1'b0;
      st_r.phase          <= PH_LOAD;
      st_r.powerup_timer_cnt       <= '0;
      st_r.cfg_word       <= CFG_RESET_VAL;
      st_r.pgm_rdata      <= DATA_ZERO;
      st_r.cpu_rdata      <= DATA_ZERO;
      st_r.cpu_wr_blocked <= 1'b0;
      st_r.pgm_wr_blocked <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // data outputs straight from the state
  assign o_pgm_rdata      = st_r.pgm_rdata;
  assign o_cpu_rdata      = st_r.cpu_rdata;
  assign o_pgm_wr_blocked = st_r.pgm_wr_blocked;
  assign o_cpu_wr_blocked = st_r.cpu_wr_blocked;
  assign o_prog_mode      = st_r.prog_mode;
  assign o_cfg            = cfg;

  // decoded enables; brown-out is gated off in sleep
  assign o_debug_mode_en       = ~cfg.debug_enable_n;
  assign o_brownout_reset_en   = cfg.brownout_reset_enable &&
                                 !i_sleep;
  assign o_ext_reset_pin_en    = cfg.ext_reset_pin_select;
  assign o_reset_pin_pullup_en = cfg.ext_reset_pin_select;
  assign o_powerup_timer_en    = ~cfg.powerup_timer_enable_n;
  assign o_watchdog_en         = cfg.watchdog_enable;

  // core stays in reset until loaded and any stretch is over
  assign o_core_reset_hold = (st_r.phase != PH_RUN);
  assign o_cfg_valid       = (st_r.phase != PH_LOAD);

endmodule

`default_nettype wire

// file: hw/dfwp_pkg.sv
// package of the fuse word protection block: addresses, field positions,
// reset values, timing figures, phase codes and the packed state carriers.
// assumes one 125 MHz clock domain and 14-bit program-space words.
package dfwp_pkg;

  // word widths of program space
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned DATA_W = 14;

  // program-space word addresses as printed
  localparam logic [13:0] CFG_WORD_ADDR   = 14'h2007;
  localparam logic [13:0] ID_FIRST_ADDR   = 14'h2000;
  localparam logic [13:0] ID_LAST_ADDR    = 14'h2003;
  localparam logic [13:0] PM_LAST_ADDR    = 14'h0FFF;
  localparam logic [13:0] LOCK_LOW_END    = 14'h03FF;
  localparam logic [13:0] LOCK_HALF_END   = 14'h07FF;

  // field positions inside the fuse word
  localparam int unsigned DEBUG_EN_N_BIT  = 13;
  localparam int unsigned WRT_HI_BIT      = 11;
  localparam int unsigned WRT_LO_BIT      = 10;
  localparam int unsigned BOR_EN_BIT      = 8;
  localparam int unsigned CP_N_BIT        = 6;
  localparam int unsigned RST_PIN_SEL_BIT = 5;
  localparam int unsigned POWERUP_TIMER_EN_N_BIT   = 4;
  localparam int unsigned WDT_EN_BIT      = 3;

  // implemented bits; the rest carry no function and read as zero
  localparam logic [13:0] CFG_IMPL_MASK   = 14'h2D78;
  // latch value before the first load: the erased word, masked
  localparam logic [13:0] CFG_RESET_VAL   = 14'h2D78;
  localparam logic [13:0] DATA_ZERO       = 14'h0000;

  // self-write lock range codes
  localparam logic [1:0] WRT_OFF  = 2'b11;
  localparam logic [1:0] WRT_LOW  = 2'b10;
  localparam logic [1:0] WRT_HALF = 2'b01;
  localparam logic [1:0] WRT_ALL  = 2'b00;

  // power-up timer period and clock rate
  localparam int unsigned POWERUP_TIMER_TIME_US = 1000;
  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned POWERUP_TIMER_CYCLES  = POWERUP_TIMER_TIME_US * CLK_MHZ;
  localparam int unsigned POWERUP_TIMER_CNT_W   = 24;

  // start-up phases
  typedef enum logic [1:0] {
    PH_LOAD = 2'b00,
    PH_POWERUP_TIMER = 2'b01,
    PH_RUN  = 2'b10
  } dfwp_phase_e;

  // decoded settings handed to the consumers
  typedef struct packed {
    logic       debug_enable_n;
    logic [1:0] self_write_lock_range;
    logic       brownout_reset_enable;
    logic       code_protect_n;
    logic       ext_reset_pin_select;
    logic       powerup_timer_enable_n;
    logic       watchdog_enable;
  } dfwp_cfg_s;

  // complete state of the block
  typedef struct packed {
    logic [2:0]            pin_sync;
    logic                  prog_mode;
    dfwp_phase_e           phase;
    logic [POWERUP_TIMER_CNT_W-1:0] powerup_timer_cnt;
    logic [13:0]           cfg_word;
    logic [13:0]           pgm_rdata;
    logic [13:0]           cpu_rdata;
    logic                  cpu_wr_blocked;
    logic                  pgm_wr_blocked;
  } dfwp_st_s;

endpackage

// file: testbench/dfwp_fuse_word_tb_top.sv
// self-checking bench: programmer and cpu tasks against a reference model.
// assumes the memory model seeds words with address xor 1555h.
`timescale 1ns/1ps
`default_nettype none
module dfwp_fuse_word_tb_top;
  import dfwp_pkg::*;
  localparam int P = 8;
  logic        i_mclk, i_rst_n, i_last_reset_por, i_sleep, i_prog_mode_pin;
  logic        i_pgm_wr, i_pgm_rd, i_cpu_wr, i_cpu_rd, o_mem_wr, o_fuse_wr;
  logic [13:0] i_pgm_addr, i_pgm_wdata, i_cpu_addr, i_cpu_wdata, o_mem_addr;
  logic [13:0] o_mem_wdata, i_mem_rdata, i_fuse_nv, o_fuse_wdata;
  logic [13:0] o_pgm_rdata, o_cpu_rdata, fuse_m, cfg_m, val;
  logic        o_pgm_wr_blocked, o_cpu_wr_blocked, o_debug_mode_en, prog;
  logic        o_brownout_reset_en, o_ext_reset_pin_en, o_reset_pin_pullup_en;
  logic        o_powerup_timer_en, o_watchdog_en, o_core_reset_hold;
  logic        o_cfg_valid, o_prog_mode;
  dfwp_cfg_s   o_cfg;
  logic [13:0] mem_m [4096];
  logic [13:0] id_m [4];
  logic [13:0] edges [6] = '{14'h03FF, 14'h0400, 14'h07FF, 14'h0800,
                             14'h0FFF, 14'h2001};
  int          lims [4] = '{4095, 2047, 1023, -1};
  int          seed = 32'h43245580;
  int          err_total, comparisons;

  dfwp_fuse_word #(.POWERUP_TIMER_CYCLES_P(P)) dfwp_fuse_word_inst (.*);
  dfwp_mem_model dfwp_mem_model_inst (.i_mclk(i_mclk), .i_addr(o_mem_addr),
    .i_wdata(o_mem_wdata), .i_wr(o_mem_wr), .o_rdata(i_mem_rdata),
    .i_fuse_wdata(o_fuse_wdata), .i_fuse_wr(o_fuse_wr), .o_fuse_nv(i_fuse_nv));

  // 125 MHz clock
  always #4 i_mclk = ~i_mclk;

  task automatic chk(input string nm, input logic [13:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one strobe cycle on either port; model decides answer and refusal
  task automatic acc(input logic cpu, w, input logic [13:0] a, d);
    logic [13:0] e;
    logic        ok;
    @(posedge i_mclk);
    if (cpu) {i_cpu_wr, i_cpu_rd, i_cpu_addr, i_cpu_wdata} <= {w, !w, a, d};
    else {i_pgm_wr, i_pgm_rd, i_pgm_addr, i_pgm_wdata} <= {w, !w, a, d};
    e = 14'h0000;
    ok = 1'b0;
    if (cpu && !prog && a <= 14'h0FFF) begin
      e = mem_m[a];
      ok = int'(a) > lims[cfg_m[11:10]];
    end else if (!cpu && prog && a <= 14'h0FFF && cfg_m[6]) begin
      e = mem_m[a];
      ok = 1'b1;
    end else if (!cpu && prog && a inside {[14'h2000:14'h2003]}) begin
      e = id_m[a[1:0]];
      ok = 1'b1;
    end else if (!cpu && prog && a == CFG_WORD_ADDR) begin
      e = fuse_m & CFG_IMPL_MASK;
      ok = 1'b1;
    end
    if (w && ok && a == CFG_WORD_ADDR) fuse_m = d;
    else if (w && ok && a <= 14'h0FFF) mem_m[a] = d;
    else if (w && ok) id_m[a[1:0]] = d;
    @(posedge i_mclk);
    {i_cpu_wr, i_cpu_rd, i_pgm_wr, i_pgm_rd} <= 4'h0;
    #1;
    if (w) chk("write refusal", 14'(!ok && (cpu || a != CFG_WORD_ADDR)),
               cpu ? o_cpu_wr_blocked : o_pgm_wr_blocked);
    else chk("read data", e, cpu ? o_cpu_rdata : o_pgm_rdata);
  endtask

  // reset with a chosen power-on flag, then time the start-up hold
  task automatic restart(input logic por);
    int n;
    @(posedge i_mclk);
    {i_rst_n, i_last_reset_por} <= {1'b0, por};
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    cfg_m = fuse_m & CFG_IMPL_MASK;
    n = 0;
    do begin
      @(posedge i_mclk);
      #1;
      n++;
    end while (o_core_reset_hold !== 1'b0 && n < 4 * P);
    val = 14'(por && !cfg_m[4] ? n > P : n <= 2);
    chk("hold length", 14'h0001, val);
    chk("hold released", 14'h0000, o_core_reset_hold);
    chk("settings valid", 14'h0001, o_cfg_valid);
  endtask

  // decoded settings against the latched word, sleep set at random
  task automatic chk_cfg();
    logic [13:0] c;
    c = cfg_m;
    @(posedge i_mclk);
    i_sleep <= 1'($random(seed));
    #1;
    chk("settings", {c[13], c[11:10], c[8], c[6:3]}, o_cfg);
    chk("debug mode", !c[13], o_debug_mode_en);
    chk("brown-out", c[8] && !i_sleep, o_brownout_reset_en);
    chk("reset pin", {c[5], c[5]},
        {o_ext_reset_pin_en, o_reset_pin_pullup_en});
    chk("power-up timer", !c[4], o_powerup_timer_en);
    chk("watchdog", c[3], o_watchdog_en);
  endtask

  task automatic set_prog(input logic p);
    int n;
    @(posedge i_mclk);
    i_prog_mode_pin <= p;
    n = 0;
    while (o_prog_mode !== p && n < 16) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    chk("program mode", p, o_prog_mode);
    prog = p;
  endtask

  // a hang is cut short well past the expected run length
  initial begin
    repeat (20000) @(posedge i_mclk);
    err_total++;
    wrap_up();
  end

  initial begin
    {i_mclk, i_rst_n, i_last_reset_por, i_sleep, i_prog_mode_pin, prog} = '0;
    {i_pgm_wr, i_pgm_rd, i_cpu_wr, i_cpu_rd, err_total, comparisons} = '0;
    {i_pgm_addr, i_pgm_wdata, i_cpu_addr, i_cpu_wdata} = '0;
    for (int k = 0; k < 4096; k++) begin
      mem_m[k] = 14'(k) ^ 14'h1555;
    end
    for (int k = 0; k < 4; k++) begin
      id_m[k] = 14'h0100 + 14'(k);
    end
    fuse_m = 14'h3FFF;
    restart(1'b1);
    chk_cfg();
    acc(1'b0, 1'b0, 14'h0100, 14'h0000);
    // every lock code with and without code protection
    for (int i = 0; i < 8; i++) begin
      set_prog(1'b1);
      val = 14'($random(seed));
      val[11:10] = 2'(i);
      val[6] = i[2];
      val[13] = (i != 5);
      acc(1'b0, 1'b1, CFG_WORD_ADDR, val);
      chk_cfg();
      acc(1'b0, 1'b1, 14'h2000 + 14'(i % 4), 14'($random(seed)));
      acc(1'b0, 1'b0, 14'h2000 + 14'(i % 4), 14'h0000);
      acc(1'b0, 1'b1, 14'h0200, 14'($random(seed)));
      acc(1'b0, 1'b0, 14'h0200, 14'h0000);
      acc(1'b0, 1'b0, CFG_WORD_ADDR, 14'h0000);
      acc(1'b0, 1'b0, 14'h2005, 14'h0000);
      acc(1'b1, 1'b0, 14'h0200, 14'h0000);
      set_prog(1'b0);
      restart(1'($random(seed)));
      chk_cfg();
      foreach (edges[j]) begin
        acc(1'b1, 1'b1, edges[j], 14'($random(seed)));
        acc(1'b1, 1'b0, edges[j], 14'h0000);
      end
    end
    wrap_up();
  end
endmodule
`default_nettype wire

// file: testbench/dfwp_mem_model.sv
// program memory, id words and fuse cell standing behind the block.
// assumes combinational reads and writes taken at the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module dfwp_mem_model (
  // clock
  input  wire logic        i_mclk,
  // array port
  input  wire logic [13:0] i_addr,
  input  wire logic [13:0] i_wdata,
  input  wire logic        i_wr,
  output logic      [13:0] o_rdata,
  // fuse cell port
  input  wire logic [13:0] i_fuse_wdata,
  input  wire logic        i_fuse_wr,
  output logic      [13:0] o_fuse_nv
);
  logic [13:0] mem [4096];
  logic [13:0] ids [4];
  logic [13:0] pat;
  // known seed contents, erased fuse word
  initial begin
    for (int k = 0; k < 4096; k++) begin
      mem[k] = 14'(k) ^ 14'h1555;
    end
    for (int k = 0; k < 4; k++) begin
      ids[k] = 14'h0100 + 14'(k);
    end
    o_fuse_nv = 14'h3FFF;
    pat = 14'h2AAA;
  end
  // unmapped places toggle so no stale word can pass as an answer
  always_comb begin
    o_rdata = pat;
    if (i_addr <= 14'h0FFF) begin
      o_rdata = mem[i_addr[11:0]];
    end else if (i_addr inside {[14'h2000:14'h2003]}) begin
      o_rdata = ids[i_addr[1:0]];
    end
  end
  // writes land at the edge that carries the strobe
  always @(posedge i_mclk) begin
    pat <= ~pat;
    if (i_wr && i_addr <= 14'h0FFF) begin
      mem[i_addr[11:0]] <= i_wdata;
    end else if (i_wr && i_addr inside {[14'h2000:14'h2003]}) begin
      ids[i_addr[1:0]] <= i_wdata;
    end
    if (i_fuse_wr) begin
      o_fuse_nv <= i_fuse_wdata;
    end
  end
endmodule
`default_nettype wire

// file: testbench/dfwp_monitor.sv
// checker of the fuse word block: decode, guard and stability relations.
// assumes one clock, synchronous active-low reset, top ports only.
`timescale 1ns/1ps
`default_nettype none
module dfwp_monitor
  import dfwp_pkg::*;
(
  // clock and reset
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  // requests
  input wire logic        i_sleep,
  input wire logic [13:0] i_pgm_addr,
  input wire logic        i_pgm_rd,
  input wire logic [13:0] i_cpu_addr,
  input wire logic        i_cpu_wr,
  input wire logic        i_cpu_rd,
  input wire logic [13:0] i_mem_rdata,
  // answers and settings
  input wire logic [13:0] o_pgm_rdata,
  input wire logic [13:0] o_cpu_rdata,
  input wire logic        o_cpu_wr_blocked,
  input wire logic        o_mem_wr,
  input wire dfwp_cfg_s   o_cfg,
  input wire logic        o_debug_mode_en,
  input wire logic        o_brownout_reset_en,
  input wire logic        o_watchdog_en,
  input wire logic        o_cfg_valid,
  input wire logic        o_prog_mode
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  // decoded enables against the latched fields
  chk_debug_decode: assert property (
    o_debug_mode_en == !o_cfg.debug_enable_n)
    else $error("debug mode enable disagrees with its field");
  chk_brownout_sleep: assert property (
    o_brownout_reset_en == (o_cfg.brownout_reset_enable && !i_sleep))
    else $error("brown-out enable wrong for sleep state");
  chk_watchdog_decode: assert property (
    o_watchdog_en == o_cfg.watchdog_enable)
    else $error("watchdog enable disagrees with its field");
  // settings frozen once latched; a fuse write must wait for reset
  chk_cfg_frozen: assert property (
    o_cfg_valid && $past(o_cfg_valid) |-> $stable(o_cfg))
    else $error("settings moved without a reset");
  // access guards
  chk_cp_read_zero: assert property (
    i_pgm_rd && o_prog_mode && !o_cfg.code_protect_n &&
    i_pgm_addr <= 14'h0FFF |=> o_pgm_rdata == 14'h0000)
    else $error("protected read returned data");
  chk_cpu_read_pass: assert property (
    i_cpu_rd && !o_prog_mode && i_cpu_addr <= 14'h0FFF |=>
    o_cpu_rdata == $past(i_mem_rdata))
    else $error("cpu read did not return the array word");
  chk_lock_low_write: assert property (
    i_cpu_wr && !o_prog_mode && o_cfg.self_write_lock_range != 2'b11 &&
    i_cpu_addr <= 14'h03FF |-> !o_mem_wr ##1 o_cpu_wr_blocked)
    else $error("locked self-write went through");
  chk_id_hidden: assert property (
    i_cpu_rd && i_cpu_addr inside {[14'h2000:14'h2003]} |=>
    o_cpu_rdata == 14'h0000)
    else $error("cpu saw an id word");
endmodule

bind dfwp_fuse_word dfwp_monitor dfwp_monitor_inst (
  .i_mclk              (i_mclk),
  .i_rst_n             (i_rst_n),
  .i_sleep             (i_sleep),
  .i_pgm_addr          (i_pgm_addr),
  .i_pgm_rd            (i_pgm_rd),
  .i_cpu_addr          (i_cpu_addr),
  .i_cpu_wr            (i_cpu_wr),
  .i_cpu_rd            (i_cpu_rd),
  .i_mem_rdata         (i_mem_rdata),
  .o_pgm_rdata         (o_pgm_rdata),
  .o_cpu_rdata         (o_cpu_rdata),
  .o_cpu_wr_blocked    (o_cpu_wr_blocked),
  .o_mem_wr            (o_mem_wr),
  .o_cfg               (o_cfg),
  .o_debug_mode_en     (o_debug_mode_en),
  .o_brownout_reset_en (o_brownout_reset_en),
  .o_watchdog_en       (o_watchdog_en),
  .o_cfg_valid         (o_cfg_valid),
  .o_prog_mode         (o_prog_mode)
);
`default_nettype wire
